// *** verilog/siot_regs.svh ***
// constants for the servo input/output override and test-mode block
`ifndef SIOT_REGS_SVH
`define SIOT_REGS_SVH

// ==========================================================
// command codes and data numbers
`define SIOT_CMD_DEV_SET    8'h92
`define SIOT_CMD_IO_GATE    8'h90
`define SIOT_CMD_TEST_SEL   8'h8B
`define SIOT_CMD_TEST_DATA  8'hA0
`define SIOT_DNO_DEV_NORM   8'h60
`define SIOT_DNO_DEV_TEST   8'h00
`define SIOT_DNO_IN_DIS     8'h00
`define SIOT_DNO_IN_EN      8'h10
`define SIOT_DNO_OUT_DIS    8'h03
`define SIOT_DNO_OUT_EN     8'h13
`define SIOT_DNO_TEST_SEL   8'h00
`define SIOT_DNO_TC_CLR     8'h12
`define SIOT_KEY            32'h0000_1EA5
`define SIOT_MODE_LAST      32'h0000_0004

// ==========================================================
// device word layout
`define SIOT_BIT_SERVO_ON   5'h00
`define SIOT_BIT_FWD_LIMIT  5'h01
`define SIOT_BIT_REV_LIMIT  5'h02
`define SIOT_BIT_FWD_START  5'h0B
`define SIOT_BIT_REV_START  5'h0C
`define SIOT_BIT_FORCED_STP 5'h10
`define SIOT_DEV_USED       32'h6FFF_187F
`define SIOT_DEV_ALWAYS     32'h0001_0006

// ==========================================================
// register map, reset values, fields
`define SIOT_OFS_CTRL       8'h00
`define SIOT_OFS_STATUS     8'h04
`define SIOT_OFS_DEV_NORM   8'h08
`define SIOT_OFS_DEV_TEST   8'h0C
`define SIOT_OFS_DEV_EFF    8'h10
`define SIOT_CTRL_RST       32'h0000_0001
`define SIOT_CTRL_EN        0
`define SIOT_CTRL_LOCK_CLR  1

// ==========================================================
// timing
`define SIOT_WDOG_MS        32'h0000_01F4
`define SIOT_CLK_KHZ        32'h0001_86A0

`endif

// *** verilog/siot_pkg.sv ***
// types shared by the override and test-mode block
package siot_pkg;

    // ==========================================================
    // test operation modes
    typedef enum logic [2:0] {
        SIOT_MODE_OFF  = 3'b000,
        SIOT_MODE_JOG  = 3'b001,
        SIOT_MODE_POS  = 3'b010,
        SIOT_MODE_NOMO = 3'b011,
        SIOT_MODE_DOUT = 3'b100
    } siot_mode_t;

    // ==========================================================
    // bus channel states
    typedef enum logic [0:0] {
        SIOT_BUS_IDLE = 1'b0,
        SIOT_BUS_RESP = 1'b1
    } siot_bus_t;

endpackage : siot_pkg

// *** verilog/siot_hex_dec.sv ***
// hexadecimal character field to 32-bit word decoder
`timescale 1ns/1ps

module siot_hex_dec
(
    input  wire logic [63:0] chars_in,  // eight ascii chars, msb first
    output logic      [31:0] value_out, // decoded word
    output logic             bad_out    // a char was not hex
);
    logic [7:0] bad_nib;

    // ==========================================================
    // one decoder per nibble
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_nib
            logic [7:0] ch;
            assign ch = chars_in[gi*8 +: 8];
            always_comb
            begin
                bad_nib[gi] = 1'b0;
                if (ch >= 8'h30 && ch <= 8'h39)
                    value_out[gi*4 +: 4] = 4'(ch - 8'h30);
                else if (ch >= 8'h41 && ch <= 8'h46)
                    value_out[gi*4 +: 4] = 4'(ch - 8'h37);
                else if (ch >= 8'h61 && ch <= 8'h66)
                    value_out[gi*4 +: 4] = 4'(ch - 8'h57);
                else
                begin
                    value_out[gi*4 +: 4] = 4'h0;
                    bad_nib[gi]          = 1'b1;
                end
            end
        end
    endgenerate

    assign bad_out = |bad_nib;

endmodule : siot_hex_dec

// *** verilog/siot_wdog.sv ***
// communication-loss watchdog for test operation
`timescale 1ns/1ps

module siot_wdog
#(
    parameter int unsigned LIMIT = 50000000 // cycles of silence allowed
)
(
    input  wire logic core_clk_in,  // core clock
    input  wire logic rst_b_in,     // synchronous reset, active low
    input  wire logic arm_in,       // watchdog active
    input  wire logic kick_in,      // a command arrived
    output logic      expire_out    // pulse: silence exceeded limit
);
    logic [31:0] cnt_q;
    logic        fired_q;

    // ==========================================================
    // count silence; saturate after firing so it fires once
    always_ff @(posedge core_clk_in)
    begin
        if (!rst_b_in || !arm_in || kick_in)
        begin
            cnt_q   <= 32'h0000_0000;
            fired_q <= 1'b0;
        end
        else if (!fired_q)
        begin
            cnt_q   <= cnt_q + 32'h0000_0001;
            fired_q <= (cnt_q == LIMIT);
        end
    end

    // strictly more than the limit, so the pulse is one cycle late
    always_ff @(posedge core_clk_in)
    begin
        if (!rst_b_in)
            expire_out <= 1'b0;
        else
            expire_out <= arm_in && !kick_in && !fired_q
                          && (cnt_q == LIMIT);
    end

endmodule : siot_wdog

// *** verilog/siot_top.sv ***
// servo input/output override, disable and test-mode command handler
// Notes on behaviour
// - device state is last received word only
// - cmd 92 dno 60 sets override word
// - hex characters decode to bits 31..0
// - low word bits map servo inputs
// - high word bits map servo inputs
// - disabled inputs read off, zero, absent
// - forced stop and limits never disabled
// - cmd 90 dno 00 key disables inputs
// - cmd 90 dno 10 key enables inputs
// - dno 03/13 disable/enable outputs with key
// - cmd 92 dno 00 sets test word
// - cmd 8B selects test mode 0..4
// - silence over 0.5 s in a test mode stops and locks
//
// Our own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "siot_regs.svh"

module siot_top
#(
    parameter int unsigned ADDR_W    = 8,  // axi address width
    parameter int unsigned ANALOG_W  = 12, // analog sample width
    parameter int unsigned WDOG_CYC  = `SIOT_WDOG_MS * `SIOT_CLK_KHZ // 0.5 s
)
(
    input  wire logic                core_clk_in,     // 100 MHz clock
    input  wire logic                rst_b_in,        // sync reset, low
    // axi4-lite slave
    input  wire logic [ADDR_W-1:0]   s_axi_awaddr,    // write address
    input  wire logic                s_axi_awvalid,   // write addr valid
    output logic                     s_axi_awready,   // write addr ready
    input  wire logic [31:0]         s_axi_wdata,     // write data
    input  wire logic [3:0]          s_axi_wstrb,     // byte enables
    input  wire logic                s_axi_wvalid,    // write data valid
    output logic                     s_axi_wready,    // write data ready
    output logic [1:0]               s_axi_bresp,     // write response
    output logic                     s_axi_bvalid,    // response valid
    input  wire logic                s_axi_bready,    // response ready
    input  wire logic [ADDR_W-1:0]   s_axi_araddr,    // read address
    input  wire logic                s_axi_arvalid,   // read addr valid
    output logic                     s_axi_arready,   // read addr ready
    output logic [31:0]              s_axi_rdata,     // read data
    output logic [1:0]               s_axi_rresp,     // read response
    output logic                     s_axi_rvalid,    // read data valid
    input  wire logic                s_axi_rready,    // read data ready
    // decoded commands from the frame parser
    input  wire logic                cmd_valid_in,    // command pulse
    input  wire logic [7:0]          cmd_code_in,     // command code
    input  wire logic [7:0]          cmd_dno_in,      // data number
    input  wire logic [63:0]         cmd_data_in,     // 8 ascii hex chars
    output logic                     cmd_ack_out,     // command handled
    output logic                     cmd_err_out,     // command refused
    // servo inputs and outputs
    input  wire logic [31:0]         ext_pins_in,     // external inputs
    input  wire logic [ANALOG_W-1:0] analog_in,       // adc sample
    input  wire logic                pulse_train_in,  // pulse train pin
    input  wire logic [31:0]         do_int_in,       // internal outputs
    output logic [31:0]              in_dev_out,      // effective inputs
    output logic [ANALOG_W-1:0]      analog_out,      // gated sample
    output logic                     pulse_train_out, // gated pulses
    output logic [31:0]              do_out,          // gated outputs
    output logic [2:0]               test_mode_out,   // test mode code
    output logic                     stop_lock_out,   // stop and lock
    output logic                     tc_clear_out     // clear time const
);

    // ==========================================================
    // declarations
    siot_pkg::siot_mode_t mode_q;
    siot_pkg::siot_bus_t  wr_st_q, rd_st_q;
    logic [31:0]          ctrl_q, dev_norm_q, dev_test_q, data_val;
    logic [31:0]          pins_m_q, pins_s_q, w_data_q, rd_word;
    logic [31:0]          pin_mask, dev_word, dev_eff;
    logic [ADDR_W-1:0]    aw_addr_q;
    logic [3:0]           w_strb_q;
    logic                 in_dis_q, out_dis_q, lock_q, pulse_m_q, pulse_s_q;
    logic                 data_bad, key_ok, cmd_go, cmd_known, wdog_fire;
    logic                 aw_have_q, w_have_q, wr_fire, lock_clr_wr, rd_hit;

    // ==========================================================
    // input synchronisers: pins are outside the core domain
    always_ff @(posedge core_clk_in)
    begin
        pins_m_q  <= rst_b_in ? ext_pins_in : 32'h0000_0000;
        pins_s_q  <= rst_b_in ? pins_m_q : 32'h0000_0000;
        pulse_m_q <= rst_b_in && pulse_train_in;
        pulse_s_q <= rst_b_in && pulse_m_q;
    end

    // ==========================================================
    // command data decode
    // hex characters to word
    siot_hex_dec u_hex
    (
        .chars_in  (cmd_data_in),
        .value_out (data_val),
        .bad_out   (data_bad)
    );
    assign key_ok = !data_bad && (data_val == `SIOT_KEY);
    assign cmd_go = cmd_valid_in && ctrl_q[`SIOT_CTRL_EN];

    // ==========================================================
    // decide whether a command is known and acceptable
    always_comb
    begin
        cmd_known = 1'b0;
        if (cmd_code_in == `SIOT_CMD_DEV_SET)
            cmd_known = !data_bad &&
                        (cmd_dno_in == `SIOT_DNO_DEV_NORM ||
                         cmd_dno_in == `SIOT_DNO_DEV_TEST);
        else if (cmd_code_in == `SIOT_CMD_IO_GATE)
            cmd_known = key_ok &&
                        (cmd_dno_in == `SIOT_DNO_IN_DIS  ||
                         cmd_dno_in == `SIOT_DNO_IN_EN   ||
                         cmd_dno_in == `SIOT_DNO_OUT_DIS ||
                         cmd_dno_in == `SIOT_DNO_OUT_EN);
        else if (cmd_code_in == `SIOT_CMD_TEST_SEL)
            cmd_known = !data_bad &&
                        cmd_dno_in == `SIOT_DNO_TEST_SEL &&
                        data_val <= `SIOT_MODE_LAST;
        else if (cmd_code_in == `SIOT_CMD_TEST_DATA)
            cmd_known = key_ok && cmd_dno_in == `SIOT_DNO_TC_CLR;
    end

    // ==========================================================
    // override words: each write replaces the whole word
    always_ff @(posedge core_clk_in)
    begin
        if (!rst_b_in)
        begin
            dev_norm_q <= 32'h0000_0000;
            dev_test_q <= 32'h0000_0000;
        end
        else if (cmd_go && cmd_known && cmd_code_in == `SIOT_CMD_DEV_SET)
        begin
            if (cmd_dno_in == `SIOT_DNO_DEV_NORM)
                dev_norm_q <= data_val;
            else
                dev_test_q <= data_val;
        end
    end

    // ==========================================================
    // input and output disable state
    always_ff @(posedge core_clk_in)
    begin
        if (!rst_b_in)
        begin
            in_dis_q  <= 1'b0;
            out_dis_q <= 1'b0;
        end
        else if (cmd_go && cmd_known && cmd_code_in == `SIOT_CMD_IO_GATE)
        begin
            if (cmd_dno_in == `SIOT_DNO_IN_DIS)
                in_dis_q <= 1'b1;
            else if (cmd_dno_in == `SIOT_DNO_IN_EN)
                in_dis_q <= 1'b0;
            else if (cmd_dno_in == `SIOT_DNO_OUT_DIS)
                out_dis_q <= 1'b1;
            else
                out_dis_q <= 1'b0;
        end
    end

    // ==========================================================
    // test mode selection
    always_ff @(posedge core_clk_in)
    begin
        if (!rst_b_in)
            mode_q <= siot_pkg::SIOT_MODE_OFF;
        else if (cmd_go && cmd_known &&
                 cmd_code_in == `SIOT_CMD_TEST_SEL)
            mode_q <= siot_pkg::siot_mode_t'(data_val[2:0]);
    end
    // time-constant clear is a one-cycle request to the motion logic
    // only the keyed clear acts
    always_ff @(posedge core_clk_in)
        tc_clear_out <= rst_b_in && cmd_go && cmd_known &&
                        cmd_code_in == `SIOT_CMD_TEST_DATA;

    // ==========================================================
    // communication-loss watchdog; any command, even refused, kicks
    // 0.5 s silence watchdog
    siot_wdog
    #(
        .LIMIT (WDOG_CYC)
    )
    u_wdog
    (
        .core_clk_in (core_clk_in),
        .rst_b_in    (rst_b_in),
        .arm_in      (mode_q != siot_pkg::SIOT_MODE_OFF),
        .kick_in     (cmd_valid_in),
        .expire_out  (wdog_fire)
    );
    // stop lock: expiry wins over any clear in the same cycle
    always_ff @(posedge core_clk_in)
    begin
        if (!rst_b_in)
            lock_q <= 1'b0;
        else if (wdog_fire)
            lock_q <= 1'b1;
        else if (lock_clr_wr || mode_q == siot_pkg::SIOT_MODE_OFF)
            lock_q <= 1'b0;
    end

    // ==========================================================
    // effective input devices
    always_comb
    begin
        pin_mask = in_dis_q ? `SIOT_DEV_ALWAYS : 32'hFFFF_FFFF;
        dev_word = (mode_q != siot_pkg::SIOT_MODE_OFF) ? dev_test_q
                                                        : dev_norm_q;
        dev_eff  = ((pins_s_q & pin_mask) | dev_word) & `SIOT_DEV_USED;
        // locked: starts dropped so the motor decelerates and holds
        dev_eff[`SIOT_BIT_FWD_START] = dev_eff[`SIOT_BIT_FWD_START] && !lock_q;
        dev_eff[`SIOT_BIT_REV_START] = dev_eff[`SIOT_BIT_REV_START] && !lock_q;
    end
    // registered servo-side outputs; reset folded into the data path
    always_ff @(posedge core_clk_in)
    begin
        in_dev_out      <= rst_b_in ? dev_eff : 32'h0000_0000;
        analog_out      <= (rst_b_in && !in_dis_q) ? analog_in : '0;
        pulse_train_out <= rst_b_in && pulse_s_q && !in_dis_q;
        do_out          <= (rst_b_in && !out_dis_q) ? do_int_in : '0;
    end
    assign test_mode_out = mode_q;
    assign stop_lock_out = lock_q;
    // command answer, one cycle after the strobe
    always_ff @(posedge core_clk_in)
    begin
        cmd_ack_out <= rst_b_in && cmd_valid_in;
        cmd_err_out <= rst_b_in && cmd_valid_in && !(cmd_go && cmd_known);
    end

    // ==========================================================
    // axi4-lite write channel: address and data in either order
    assign s_axi_awready = !aw_have_q && wr_st_q == siot_pkg::SIOT_BUS_IDLE;
    assign s_axi_wready  = !w_have_q && wr_st_q == siot_pkg::SIOT_BUS_IDLE;
    assign wr_fire       = aw_have_q && w_have_q;
    assign s_axi_bvalid  = wr_st_q == siot_pkg::SIOT_BUS_RESP;
    always_ff @(posedge core_clk_in)
    begin
        if (!rst_b_in)
        begin
            aw_have_q   <= 1'b0;
            w_have_q    <= 1'b0;
            aw_addr_q   <= '0;
            w_data_q    <= 32'h0000_0000;
            w_strb_q    <= 4'h0;
            wr_st_q     <= siot_pkg::SIOT_BUS_IDLE;
            s_axi_bresp <= 2'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            case (wr_st_q)
                siot_pkg::SIOT_BUS_IDLE:
                    if (wr_fire)
                    begin
                        aw_have_q   <= 1'b0;
                        w_have_q    <= 1'b0;
                        wr_st_q     <= siot_pkg::SIOT_BUS_RESP;
                        s_axi_bresp <= (aw_addr_q[7:0] == `SIOT_OFS_CTRL)
                                       ? 2'h0 : 2'h2;
                    end
                siot_pkg::SIOT_BUS_RESP:
                    if (s_axi_bready)
                        wr_st_q <= siot_pkg::SIOT_BUS_IDLE;
                default:
                    wr_st_q <= siot_pkg::SIOT_BUS_IDLE;
            endcase
        end
    end
    // control register; only the low byte carries fields
    assign lock_clr_wr = wr_fire && wr_st_q == siot_pkg::SIOT_BUS_IDLE &&
                         aw_addr_q[7:0] == `SIOT_OFS_CTRL && w_strb_q[0] &&
                         w_data_q[`SIOT_CTRL_LOCK_CLR];
    always_ff @(posedge core_clk_in)
    begin
        if (!rst_b_in)
            ctrl_q <= `SIOT_CTRL_RST;
        else if (wr_fire && wr_st_q == siot_pkg::SIOT_BUS_IDLE &&
                 aw_addr_q[7:0] == `SIOT_OFS_CTRL && w_strb_q[0])
            ctrl_q <= {31'h0000_0000, w_data_q[`SIOT_CTRL_EN]};
    end

    // ==========================================================
    // axi4-lite read channel
    always_comb
    begin
        rd_hit  = 1'b1;
        rd_word = 32'h0000_0000;
        if (s_axi_araddr[7:0] == `SIOT_OFS_CTRL)
            rd_word = ctrl_q;
        else if (s_axi_araddr[7:0] == `SIOT_OFS_STATUS)
            rd_word = {25'h000_0000, mode_q, 1'b0,
                       lock_q, out_dis_q, in_dis_q};
        else if (s_axi_araddr[7:0] == `SIOT_OFS_DEV_NORM)
            rd_word = dev_norm_q;
        else if (s_axi_araddr[7:0] == `SIOT_OFS_DEV_TEST)
            rd_word = dev_test_q;
        else if (s_axi_araddr[7:0] == `SIOT_OFS_DEV_EFF)
            rd_word = in_dev_out;
        else
            rd_hit = 1'b0;
    end
    assign s_axi_arready = rd_st_q == siot_pkg::SIOT_BUS_IDLE;
    assign s_axi_rvalid  = rd_st_q == siot_pkg::SIOT_BUS_RESP;
    always_ff @(posedge core_clk_in)
    begin
        if (!rst_b_in)
        begin
            rd_st_q     <= siot_pkg::SIOT_BUS_IDLE;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end
        else
        begin
            case (rd_st_q)
                siot_pkg::SIOT_BUS_IDLE:
                    if (s_axi_arvalid)
                    begin
                        s_axi_rdata <= rd_word;
                        s_axi_rresp <= rd_hit ? 2'h0 : 2'h2;
                        rd_st_q     <= siot_pkg::SIOT_BUS_RESP;
                    end
                siot_pkg::SIOT_BUS_RESP:
                    if (s_axi_rready)
                        rd_st_q <= siot_pkg::SIOT_BUS_IDLE;
                default:
                    rd_st_q <= siot_pkg::SIOT_BUS_IDLE;
            endcase
        end
    end

endmodule : siot_top

// *** sim/siot_top_assertions.sv ***
// checker for the command port of siot_top
`timescale 1ns/1ps
`include "siot_regs.svh"
module siot_top_assertions
(
    input wire logic        core_clk_in,   // clock
    input wire logic        rst_b_in,      // reset, low
    input wire logic        cmd_valid_in,  // command
    input wire logic [7:0]  cmd_code_in,   // code
    input wire logic [63:0] cmd_data_in,   // ascii data
    input wire logic        cmd_ack_out,   // handled
    input wire logic        cmd_err_out,   // refused
    input wire logic [31:0] in_dev_out,    // inputs
    input wire logic [2:0]  test_mode_out, // mode
    input wire logic        stop_lock_out, // lock
    input wire logic        tc_clear_out   // clear
);
    // ==========================================================
    // command port relations on the core clock
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_b_in);
    AST_ACK:
    assert property (cmd_valid_in |=> cmd_ack_out) else $error("no ack");
    AST_NO_ACK:
    assert property (!cmd_valid_in |=> !cmd_ack_out) else $error("ack");
    AST_ERR_ACK:
    assert property (cmd_err_out |-> cmd_ack_out) else $error("lone err");
    AST_BAD_KEY:
    assert property (cmd_valid_in && cmd_code_in == 8'h90 &&
        cmd_data_in[31:24] == 8'h30 |=> cmd_err_out) else $error("key");
    AST_MODE_MAX:
    assert property (test_mode_out <= 3'd4) else $error("mode");
    AST_MODE_BAD:
    assert property (cmd_valid_in && cmd_code_in == 8'h8B &&
        cmd_data_in[7:0] == 8'h35 |=> cmd_err_out) else $error("mode 5");
    AST_UNUSED:
    assert property ((in_dev_out & ~`SIOT_DEV_USED) == 32'h0)
        else $error("unused bit");
    // two deep: the effective word is registered behind the lock
    AST_LOCK:
    assert property (stop_lock_out && $past(stop_lock_out, 2) |->
        in_dev_out[12:11] == 2'b00) else $error("start in lock");
    AST_TC:
    assert property (tc_clear_out |->
        $past(cmd_valid_in && cmd_code_in == 8'hA0)) else $error("tc");
    COV_LOCK: cover property (stop_lock_out);
    COV_TC: cover property (tc_clear_out);
    COV_ERR: cover property (cmd_err_out);
endmodule : siot_top_assertions
bind siot_top siot_top_assertions i_siot_top_assertions (.*);

// *** sim/siot_master.sv ***
// master station model driving the command port
`timescale 1ns/1ps
module siot_master
(
    input  wire logic core_clk_in,          // clock
    input  wire logic cmd_err_in,           // refusal
    output logic        cmd_valid_out = 0,  // command
    output logic [7:0]  cmd_code_out = 0,   // code
    output logic [7:0]  cmd_dno_out = 0,    // data number
    output logic [63:0] cmd_data_out = 0    // ascii chars
);
    function automatic logic [63:0] hexw(input logic [31:0] v);
        for (int i = 0; i < 8; i++)
            hexw[8*i+:8] = 8'(v[4*i+:4]) + (v[4*i+:4] < 4'hA ? 8'h30 : 8'h37);
    endfunction : hexw
    // whole word sent in every frame
    task automatic send(input logic [7:0] c, d, input logic [31:0] v,
                        output logic err);
        cmd_valid_out <= 1'b1;
        cmd_code_out  <= c;
        cmd_dno_out   <= d;
        cmd_data_out  <= hexw(v);
        @(posedge core_clk_in);
        cmd_valid_out <= 1'b0;
        cmd_data_out  <= ~hexw(v); // stale data must not look valid
        @(posedge core_clk_in);
        err = cmd_err_in;
    endtask : send
endmodule : siot_master

// *** sim/siot_top_tb.sv ***
// self-checking bench for siot_top
`timescale 1ns/1ps
`include "siot_regs.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
$display("unexpected at %0t: %h vs %h", $time, (a), (b)); end end
module siot_top_tb;
    logic core_clk_in = 0, rst_b_in = 0, pulse_train_in = 1, err;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, cmd_valid_in;
    logic cmd_ack_out, cmd_err_out, pulse_train_out, stop_lock_out;
    logic tc_clear_out;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, cmd_code_in, cmd_dno_in;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [2:0] test_mode_out;
    logic [11:0] analog_in = 12'h5A5, analog_out;
    logic [31:0] s_axi_wdata = 0, ext_pins_in = 0, do_int_in = 32'hFFFF_FFFF;
    logic [31:0] s_axi_rdata, in_dev_out, do_out;
    logic [63:0] cmd_data_in;
    int fail_count = 0, n_checks = 0;
    siot_top #(.WDOG_CYC(50)) i_siot_top (.*);
    siot_master i_siot_master
    (
        .core_clk_in, .cmd_err_in(cmd_err_out), .cmd_valid_out(cmd_valid_in),
        .cmd_code_out(cmd_code_in), .cmd_dno_out(cmd_dno_in),
        .cmd_data_out(cmd_data_in)
    );
    // ==========================================================
    // clock, hang guard and verdict
    initial
    begin
        forever #5 core_clk_in = ~core_clk_in;
    end
    initial
    begin
        #100000;
        fail_count++;
        wrap_up();
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up
    // ==========================================================
    // bus and command helpers, all entered just after a clock edge
    task automatic axw(input logic [7:0] a, input logic [31:0] d,
                       input logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do
        begin
            @(posedge core_clk_in);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
        end
        while (!s_axi_bvalid);
        `CHK(s_axi_bresp, r)
    endtask : axw
    task automatic axr(input logic [7:0] a, input logic [31:0] d,
                       input logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do
        begin
            @(posedge core_clk_in);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
        end
        while (!s_axi_rvalid);
        `CHK({s_axi_rresp, s_axi_rdata}, {r, d})
    endtask : axr
    task automatic cmd(input logic [7:0] c, d, input logic [31:0] v);
        i_siot_master.send(c, d, v, err);
    endtask : cmd
    // outputs settle one edge after the take, three after a pin change
    task automatic dev(input logic [7:0] c, d, input logic [31:0] v, e);
        cmd(c, d, v);
        repeat (3) @(posedge core_clk_in);
        `CHK(in_dev_out, e)
    endtask : dev
    // ==========================================================
    // scenarios
    task automatic t_norm();
        axr(8'h00, 32'h1, 2'b00);
        axr(8'h20, 32'h0, 2'b10);
        axw(8'h04, 32'h1, 2'b10);
        dev(8'h92, 8'h60, 32'h807, 32'h807);
        dev(8'h92, 8'h60, 32'hFFFF_FFFF, 32'h6FFF_187F);
        dev(8'h92, 8'h60, 32'h1, 32'h1);
        axr(8'h08, 32'h1, 2'b00);
    endtask : t_norm
    task automatic t_gate();
        ext_pins_in <= 32'h6FFF_187F;
        dev(8'h92, 8'h60, 32'h0, 32'h6FFF_187F);
        `CHK({analog_out, pulse_train_out}, 13'h0B4B)
        dev(8'h90, 8'h00, 32'h0EA5, 32'h6FFF_187F);
        dev(8'h90, 8'h00, 32'h1EA5, 32'h0001_0006);
        `CHK({analog_out, pulse_train_out}, 13'h0)
        dev(8'h90, 8'h03, 32'h1EA5, 32'h0001_0006);
        `CHK(do_out, 32'h0)
        dev(8'h90, 8'h13, 32'h1EA4, 32'h0001_0006);
        `CHK({err, do_out}, 33'h1_0000_0000)
        dev(8'h90, 8'h13, 32'h1EA5, 32'h0001_0006);
        `CHK(do_out, 32'hFFFF_FFFF)
        dev(8'h90, 8'h10, 32'h1EA5, 32'h6FFF_187F);
    endtask : t_gate
    task automatic t_test();
        ext_pins_in <= 0;
        dev(8'h92, 8'h60, 32'h0, 32'h0);
        dev(8'h90, 8'h00, 32'h1EA5, 32'h0);
        for (int m = 1; m < 6; m++)
        begin
            cmd(8'h8B, 8'h00, m);
            `CHK({err, test_mode_out}, {m > 4, 3'(m > 4 ? 4 : m)})
        end
        cmd(8'h8B, 8'h00, 32'h1);
        dev(8'h92, 8'h00, 32'h807, 32'h807);
        // unknown commands keep the silence timer from running out
        repeat (6)
        begin
            cmd(8'h12, 8'h00, 32'h0);
            repeat (40) @(posedge core_clk_in);
        end
        `CHK(stop_lock_out, 1'b0)
        repeat (60) @(posedge core_clk_in);
        `CHK({stop_lock_out, in_dev_out}, 33'h1_0000_0007)
        axr(8'h04, 32'h15, 2'b00);
        axw(8'h00, 32'h3, 2'b00);
        `CHK(stop_lock_out, 1'b0)
        cmd(8'hA0, 8'h12, 32'h1EA6);
        `CHK(err, 1'b1)
        cmd(8'hA0, 8'h12, 32'h1EA5);
        `CHK(err, 1'b0)
        dev(8'h8B, 8'h00, 32'h0, 32'h0);
        `CHK({stop_lock_out, test_mode_out}, 4'h0)
        dev(8'h90, 8'h10, 32'h1EA5, 32'h0);
        axw(8'h00, 32'h0, 2'b00);
        cmd(8'h92, 8'h60, 32'h1);
        `CHK(err, 1'b1)
    endtask : t_test
    initial
    begin
        repeat (12) @(posedge core_clk_in);
        rst_b_in <= 1;
        @(posedge core_clk_in);
        t_norm();
        t_gate();
        t_test();
        wrap_up();
    end
endmodule : siot_top_tb
